// ===== logic/plr_pkg.sv
// Shared constants and carrier types for the per-port link control and status registers.
package plr_pkg;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFF_LINK_CS = 12'h0d0;
    localparam logic [11:0] OFF_IRQ_STS = 12'h100;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h104;
    localparam logic [11:0] OFF_PORT_INFO = 12'h108;

    // ****************************************************************
    // Field codes and reset values.
    // ****************************************************************
    localparam logic [1:0] ASPM_OFF = 2'h0;
    localparam logic [1:0] ASPM_SUPPORT = 2'h3;
    localparam logic [3:0] SPEED_2G5 = 4'h1;
    localparam logic [3:0] SPEED_5G0 = 4'h2;
    localparam logic [3:0] SPEED_RST = SPEED_5G0;
    localparam logic [5:0] WIDTH_UP_RST = 6'h04;
    localparam logic [5:0] WIDTH_DN_RST = 6'h02;

    // ****************************************************************
    // Exit sequence lengths in ordered sets.
    // ****************************************************************
    localparam logic [12:0] EXT_FTS_COUNT = 13'h1000;
    localparam logic [12:0] EXT_TS1_COUNT = 13'h0400;
    localparam logic [12:0] NORM_FTS_COUNT = 13'h0080;
    localparam logic [12:0] NORM_TS1_COUNT = 13'h0010;

    // ****************************************************************
    // Interrupt event bit positions.
    // ****************************************************************
    localparam int unsigned IRQ_N = 5;
    localparam int unsigned EV_TRAIN_ERR = 0;
    localparam int unsigned EV_TRAIN_DONE = 1;
    localparam int unsigned EV_DL_CHANGE = 2;
    localparam int unsigned EV_BW_MGMT = 3;
    localparam int unsigned EV_BW_AUTO = 4;

    // Link control half word, bit 0 last.
    typedef struct packed {
        logic [3:0] rsvd_hi;
        logic bw_auto_ie;
        logic bw_mgmt_ie;
        logic hw_width_dis;
        logic clk_pm_en;
        logic ext_sync;
        logic common_clk;
        logic retrain;
        logic link_dis;
        logic rcb;
        logic rsvd2;
        logic [1:0] aspm;
    } plr_ctrl_t;

    localparam plr_ctrl_t CTRL_RST = '0;

    // Link status half word, bit 16 last.
    typedef struct packed {
        logic bw_auto_sts;
        logic bw_mgmt_sts;
        logic dl_active;
        logic slot_clk;
        logic training;
        logic train_err;
        logic [5:0] width;
        logic [3:0] speed;
    } plr_stat_t;

    // Port information word.
    typedef struct packed {
        logic [26:0] rsvd;
        logic clkreq_pin;
        logic slot_clk_dflt;
        logic [1:0] aspm_support;
        logic upstream;
    } plr_info_t;

    // Inputs from the training and data link machinery.
    typedef struct packed {
        logic train_start;
        logic train_done;
        logic train_fail;
        logic dl_active;
        logic [3:0] speed;
        logic [5:0] width;
        logic bw_mgmt_evt;
        logic bw_auto_evt;
    } plr_phy_in_t;

    // Controls towards the training machinery.
    typedef struct packed {
        logic aspm_l0s_en;
        logic aspm_l1_en;
        logic rx_l0s_en;
        logic link_dis;
        logic retrain;
        logic common_clk;
        logic ext_sync;
        logic hw_width_dis;
        logic [12:0] fts_count;
        logic [12:0] ts1_count;
    } plr_link_ctl_t;

    // Link state tracker.
    typedef enum logic [2:0] {
        ST_TRAIN = 3'b001,
        ST_LINK_UP = 3'b010,
        ST_DISABLED = 3'b100
    } plr_state_t;

endpackage

// ===== logic/plr_sticky_flags.sv
// Sticky event flags that set on an event and clear on a written one.
module plr_sticky_flags
    import plr_pkg::*;
#(
    parameter int unsigned N = 2
)
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Events and clears.
    input wire logic [N-1:0] set_i,
    input wire logic [N-1:0] clr_i,
    // Flags.
    output logic [N-1:0] flag_o
);

    // Each flag lets a same-cycle event win over a clear so nothing is lost.
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_flag
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    flag_o[i] <= 1'b0;
                end
                else if (set_i[i])
                begin
                    flag_o[i] <= 1'b1;
                end
                else if (clr_i[i])
                begin
                    flag_o[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

// ===== logic/plr_link_regs.sv
// Per-port link control and link status registers behind a Wishbone slave.
//
// Function
// - Two-bit field enables L0s, L1 entry.
// - Receiver may always enter L0s.
// - Completion boundary bit reads zero always.
// - Downstream link disable; upstream bit hardwired zero.
// - Downstream retrain starts training; upstream cannot.
// - Retrain bit always reads back zero.
// - Common clock bit is read-write, resets zero.
// - Extended sync lengthens FTS and TS1 exits.
// - Clock management bit governs the request pin.
// - Downstream clock management bit hardwired zero.
// - Bandwidth interrupt enables writable downstream only.
// - Speed field reports negotiated rate, resets 5G.
// - Width resets four lanes up, two down.
// - Training error set on fail, cleared on success.
// - Training bit high while link trains.
// - Slot clock bit from loadable default, resets to the strap value.
// - Data link active mirrors active state.
// - Capability reports both L0s and L1 support.
//
// Local design decision: the Wishbone slave port.
module plr_link_regs
    import plr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Straps sampled while reset is held.
    input wire logic port_upstream_i,
    input wire logic slot_clk_dflt_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Training and data link machinery.
    input wire plr_phy_in_t phy_i,
    output plr_link_ctl_t link_o,
    // Clock request pin, open drain and active low.
    input wire logic clkreq_n_i,
    input wire logic clk_release_req_i,
    output logic clkreq_n_o,
    output logic clkreq_n_oe_o,
    // Interrupts.
    output logic lbw_irq_o,
    output logic irq_o
);

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    logic upstream;
    logic slot_clk;
    plr_ctrl_t ctrl;
    plr_ctrl_t wr_ctrl;
    plr_ctrl_t rd_ctrl;
    plr_stat_t wr_stat;
    plr_stat_t rd_stat;
    plr_info_t rd_info;
    plr_state_t state;
    plr_state_t next_state;
    logic [3:0] speed;
    logic [5:0] width;
    logic train_err;
    logic dl_active;
    logic [1:0] bw_flags;
    logic [1:0] bw_clr;
    logic [IRQ_N-1:0] irq_sts;
    logic [IRQ_N-1:0] irq_mask;
    logic [IRQ_N-1:0] irq_set;
    logic [IRQ_N-1:0] irq_clr;
    logic access;
    logic wr;
    logic wr_cs;
    logic wr_irq_sts;
    logic wr_irq_mask;
    logic retrain_go;
    logic [31:0] rd_data;

    // Word-aligned address match, used by every decode below.
    function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [ADDR_W-1:0] off);
        reg_hit = (adr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    // ****************************************************************
    // Bus decode.
    // ****************************************************************

    // A write takes effect at the edge where the master sees ack.
    assign access = wb_cyc_i & wb_stb_i;
    assign wr = access & wb_we_i & wb_ack_o;
    assign wr_cs = wr & reg_hit(wb_adr_i, OFF_LINK_CS);
    assign wr_irq_sts = wr & reg_hit(wb_adr_i, OFF_IRQ_STS);
    assign wr_irq_mask = wr & reg_hit(wb_adr_i, OFF_IRQ_MASK);
    assign wr_ctrl = plr_ctrl_t'(wb_dat_i[15:0]);
    assign wr_stat = plr_stat_t'(wb_dat_i[31:16]);

    // Retraining is only possible on a downstream port with its link enabled.
    assign retrain_go = wr_cs & wb_sel_i[0] & wr_ctrl.retrain & ~upstream & ~ctrl.link_dis;

    // ****************************************************************
    // Straps.
    // ****************************************************************

    // The port role and slot clock default are caught while reset is held.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            upstream <= port_upstream_i;
            slot_clk <= slot_clk_dflt_i;
        end
    end

    // ****************************************************************
    // Link control register.
    // ****************************************************************

    // Writable control bits; role-dependent bits are forced to zero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl <= CTRL_RST;
        end
        else if (wr_cs)
        begin
            if (wb_sel_i[0])
            begin
                ctrl.aspm <= wr_ctrl.aspm;
                ctrl.link_dis <= wr_ctrl.link_dis & ~upstream;
                ctrl.common_clk <= wr_ctrl.common_clk;
                ctrl.ext_sync <= wr_ctrl.ext_sync;
            end
            if (wb_sel_i[1])
            begin
                ctrl.clk_pm_en <= wr_ctrl.clk_pm_en & upstream;
                ctrl.hw_width_dis <= wr_ctrl.hw_width_dis;
                ctrl.bw_mgmt_ie <= wr_ctrl.bw_mgmt_ie & ~upstream;
                ctrl.bw_auto_ie <= wr_ctrl.bw_auto_ie & ~upstream;
            end
        end
    end

    // ****************************************************************
    // Link state tracking.
    // ****************************************************************

    // Disable wins, then retraining, then training outcome.
    always_comb
    begin
        next_state = state;
        case (state)
            ST_TRAIN:
            begin
                if (ctrl.link_dis)
                begin
                    next_state = ST_DISABLED;
                end
                else if (phy_i.train_done)
                begin
                    next_state = ST_LINK_UP;
                end
            end
            ST_LINK_UP:
            begin
                if (ctrl.link_dis)
                begin
                    next_state = ST_DISABLED;
                end
                else if (retrain_go || phy_i.train_start)
                begin
                    next_state = ST_TRAIN;
                end
            end
            ST_DISABLED:
            begin
                if (!ctrl.link_dis)
                begin
                    next_state = ST_TRAIN;
                end
            end
            default:
            begin
                next_state = ST_TRAIN;
            end
        endcase
    end

    // The link is assumed to be training when reset is released.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= ST_TRAIN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Training error follows the last training outcome.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            train_err <= 1'b0;
        end
        else if (phy_i.train_fail)
        begin
            train_err <= 1'b1;
        end
        else if (phy_i.train_done)
        begin
            train_err <= 1'b0;
        end
    end

    // Negotiated speed and width are taken when training succeeds.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            speed <= SPEED_RST;
            width <= port_upstream_i ? WIDTH_UP_RST : WIDTH_DN_RST;
        end
        else if (phy_i.train_done)
        begin
            speed <= phy_i.speed;
            width <= phy_i.width;
        end
    end

    // Data link active is a registered copy of the machinery's state.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dl_active <= 1'b0;
        end
        else
        begin
            dl_active <= phy_i.dl_active;
        end
    end

    // ****************************************************************
    // Event flags.
    // ****************************************************************

    // Bandwidth status flags clear on a written one in the top byte.
    assign bw_clr = (wr_cs && wb_sel_i[3]) ? {wr_stat.bw_auto_sts, wr_stat.bw_mgmt_sts} : 2'h0;

    plr_sticky_flags #(.N(2)) u_bw_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i({phy_i.bw_auto_evt, phy_i.bw_mgmt_evt}),
        .clr_i(bw_clr),
        .flag_o(bw_flags)
    );

    // Interrupt status collects training, data link and bandwidth events.
    always_comb
    begin
        irq_set = '0;
        irq_set[EV_TRAIN_ERR] = phy_i.train_fail;
        irq_set[EV_TRAIN_DONE] = phy_i.train_done;
        irq_set[EV_DL_CHANGE] = phy_i.dl_active ^ dl_active;
        irq_set[EV_BW_MGMT] = phy_i.bw_mgmt_evt;
        irq_set[EV_BW_AUTO] = phy_i.bw_auto_evt;
    end

    assign irq_clr = (wr_irq_sts && wb_sel_i[0]) ? wb_dat_i[IRQ_N-1:0] : '0;

    plr_sticky_flags #(.N(IRQ_N)) u_irq_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(irq_set),
        .clr_i(irq_clr),
        .flag_o(irq_sts)
    );

    // Interrupt mask, one enable per status bit.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_mask <= '0;
        end
        else if (wr_irq_mask && wb_sel_i[0])
        begin
            irq_mask <= wb_dat_i[IRQ_N-1:0];
        end
    end

    // Both interrupt lines are registered levels.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_o <= 1'b0;
            lbw_irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(irq_sts & irq_mask);
            lbw_irq_o <= (bw_flags[0] & ctrl.bw_mgmt_ie) | (bw_flags[1] & ctrl.bw_auto_ie);
        end
    end

    // ****************************************************************
    // Read path.
    // ****************************************************************

    // Completion boundary, retrain and reserved bits always read zero.
    always_comb
    begin
        rd_ctrl = ctrl;
        rd_ctrl.rcb = 1'b0;
        rd_ctrl.retrain = 1'b0;
        rd_ctrl.rsvd2 = 1'b0;
        rd_ctrl.rsvd_hi = '0;
        rd_stat.bw_auto_sts = bw_flags[1];
        rd_stat.bw_mgmt_sts = bw_flags[0];
        rd_stat.dl_active = dl_active;
        rd_stat.slot_clk = slot_clk;
        rd_stat.training = (state == ST_TRAIN);
        rd_stat.train_err = train_err;
        rd_stat.width = width;
        rd_stat.speed = speed;
        rd_info = '0;
        rd_info.clkreq_pin = clkreq_n_i;
        rd_info.slot_clk_dflt = slot_clk;
        rd_info.aspm_support = ASPM_SUPPORT;
        rd_info.upstream = upstream;
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb
    begin
        rd_data = '0;
        if (reg_hit(wb_adr_i, OFF_LINK_CS))
        begin
            rd_data = {rd_stat, rd_ctrl};
        end
        else if (reg_hit(wb_adr_i, OFF_IRQ_STS))
        begin
            rd_data[IRQ_N-1:0] = irq_sts;
        end
        else if (reg_hit(wb_adr_i, OFF_IRQ_MASK))
        begin
            rd_data[IRQ_N-1:0] = irq_mask;
        end
        else if (reg_hit(wb_adr_i, OFF_PORT_INFO))
        begin
            rd_data = rd_info;
        end
    end

    // Ack answers every request one cycle later and drops after one cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= access & ~wb_ack_o;
            wb_dat_o <= (access && !wb_ack_o && !wb_we_i) ? rd_data : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Link side outputs.
    // ****************************************************************

    // Controls towards the training machinery, all registered.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            link_o <= '0;
            link_o.rx_l0s_en <= 1'b1;
            link_o.fts_count <= NORM_FTS_COUNT;
            link_o.ts1_count <= NORM_TS1_COUNT;
        end
        else
        begin
            link_o.aspm_l0s_en <= ctrl.aspm[0];
            link_o.aspm_l1_en <= ctrl.aspm[1];
            link_o.rx_l0s_en <= 1'b1;
            link_o.link_dis <= ctrl.link_dis;
            link_o.retrain <= retrain_go;
            link_o.common_clk <= ctrl.common_clk;
            link_o.ext_sync <= ctrl.ext_sync;
            link_o.hw_width_dis <= ctrl.hw_width_dis;
            link_o.fts_count <= ctrl.ext_sync ? EXT_FTS_COUNT : NORM_FTS_COUNT;
            link_o.ts1_count <= ctrl.ext_sync ? EXT_TS1_COUNT : NORM_TS1_COUNT;
        end
    end

    // The request pin is held low unless clock management lets it float.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clkreq_n_o <= 1'b0;
            clkreq_n_oe_o <= 1'b1;
        end
        else
        begin
            clkreq_n_o <= 1'b0;
            clkreq_n_oe_o <= ~(ctrl.clk_pm_en & clk_release_req_i);
        end
    end

endmodule

// ===== sim/plr_link_regs_monitor.sv
// Concurrent checks on the ports of the link control and status register block.
module plr_link_regs_monitor
    import plr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched ports.
    input wire logic port_upstream_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire plr_link_ctl_t link_o,
    input wire logic clk_release_req_i,
    input wire logic clkreq_n_o,
    input wire logic clkreq_n_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic rd_cs;
    // Answer cycle of a read of the control and status word.
    assign rd_cs = wb_ack_o && !wb_we_i && (wb_adr_i[11:2] == OFF_LINK_CS[11:2]);

    // ****************************************************************
    // Bus and register checks.
    // ****************************************************************
    AST_ACK_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("answer longer than one cycle");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero when idle");
    AST_RX_L0S: assert property (link_o.rx_l0s_en)
        else $error("receiver idle entry not enabled");
    AST_EXT_SYNC: assert property (link_o.ext_sync |-> link_o.fts_count == EXT_FTS_COUNT &&
        link_o.ts1_count == EXT_TS1_COUNT)
        else $error("extended exit counts wrong");
    AST_RD_ZERO: assert property (rd_cs |-> !wb_dat_o[3] && !wb_dat_o[5])
        else $error("boundary or retrain bit read as one");
    AST_DN_CLKPM: assert property (rd_cs && !port_upstream_i |-> !wb_dat_o[8])
        else $error("downstream clock bit read as one");
    AST_UP_HARD: assert property (rd_cs && port_upstream_i |-> (wb_dat_o & 32'h0c30) == 32'h0)
        else $error("upstream fixed bit read as one");
    AST_UP_NO_CTL: assert property (port_upstream_i |-> !link_o.link_dis && !link_o.retrain)
        else $error("upstream port disabled or retrained");
    AST_CLKREQ: assert property (!clkreq_n_oe_o |-> $past(clk_release_req_i) && !clkreq_n_o)
        else $error("request pin released without cause");
endmodule

bind plr_link_regs plr_link_regs_monitor i_plr_link_regs_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .port_upstream_i(port_upstream_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
    .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_o(link_o),
    .clk_release_req_i(clk_release_req_i), .clkreq_n_o(clkreq_n_o), .clkreq_n_oe_o(clkreq_n_oe_o));

// ===== sim/plr_phy_model.sv
// Behavioural training and data link machinery facing the register block.
module plr_phy_model
    import plr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Controls from the block and the bench.
    input wire plr_link_ctl_t ctl_i,
    input wire logic kick_i,
    input wire logic fail_i,
    input wire logic [7:0] delay_i,
    input wire logic [1:0] bw_i,
    input wire logic [3:0] speed_i,
    input wire logic [5:0] width_i,
    // Status towards the block.
    output plr_phy_in_t phy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    // Counts a training attempt down and reports its outcome as one pulse.
    always_ff @(posedge clk_i)
    begin
        phy_o.train_done <= 1'b0;
        phy_o.train_fail <= 1'b0;
        phy_o.train_start <= 1'b0;
        phy_o.bw_mgmt_evt <= bw_i[0];
        phy_o.bw_auto_evt <= bw_i[1];
        phy_o.speed <= speed_i;
        phy_o.width <= width_i;
        if (rst_i || ctl_i.link_dis)
        begin
            cnt <= 8'h00;
            phy_o.dl_active <= 1'b0;
        end
        else if (ctl_i.retrain || kick_i)
        begin
            cnt <= delay_i;
            phy_o.dl_active <= 1'b0;
        end
        else if (cnt == 8'h01)
        begin
            phy_o.train_fail <= fail_i;
            phy_o.train_done <= !fail_i;
            phy_o.dl_active <= !fail_i;
            cnt <= 8'h00;
        end
        else if (cnt != 8'h00)
        begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule

// ===== sim/test_plr_link_regs.sv
// Self-checking bench for the link control and status registers.
module test_plr_link_regs
    import plr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic up = 1'b0;
    logic slot_dflt = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [11:0] wb_adr = 12'h000;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    plr_phy_in_t phy;
    plr_link_ctl_t link;
    logic clkreq_n_o;
    logic clkreq_n_oe_o;
    logic pin;
    logic rel = 1'b0;
    logic lbw;
    logic irq;
    logic kick = 1'b0;
    logic fail = 1'b0;
    logic [7:0] dly = 8'h05;
    logic [1:0] bw = 2'h0;
    logic [3:0] spd = 4'h2;
    logic [5:0] wid = 6'h02;
    logic [31:0] q;
    int err_count = 0;
    int num_checks = 0;

    // Clock and the pulled-up request pin.
    always #2 clk_i = ~clk_i;
    assign pin = clkreq_n_oe_o ? clkreq_n_o : 1'b1;

    plr_link_regs i_plr_link_regs (.clk_i(clk_i), .rst_i(rst_i), .port_upstream_i(up),
        .slot_clk_dflt_i(slot_dflt), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_adr_i(wb_adr),
        .wb_we_i(wb_we), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .phy_i(phy), .link_o(link), .clkreq_n_i(pin), .clk_release_req_i(rel), .clkreq_n_o(clkreq_n_o),
        .clkreq_n_oe_o(clkreq_n_oe_o), .lbw_irq_o(lbw), .irq_o(irq));

    plr_phy_model i_plr_phy_model (.clk_i(clk_i), .rst_i(rst_i), .ctl_i(link), .kick_i(kick),
        .fail_i(fail), .delay_i(dly), .bw_i(bw), .speed_i(spd), .width_i(wid), .phy_o(phy));

    // ****************************************************************
    // Bus access, comparison and closing tasks.
    // ****************************************************************
    task automatic wb_acc(input logic we, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        wb_acc(1'b0, a, 32'h0);
        chk(nm, e, q & m);
    endtask

    task automatic train(input logic f, input logic [3:0] s, input logic [5:0] w);
        @(posedge clk_i);
        fail <= f;
        spd <= s;
        wid <= w;
        kick <= 1'b1;
        @(posedge clk_i);
        kick <= 1'b0;
        repeat (dly + 4) @(posedge clk_i);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog that cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        end_of_test();
    end

    // Downstream port tests first, then upstream.
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFF_LINK_CS, 32'hffff_ffff, 32'h1822_0000, "dn reset");
        rd(OFF_PORT_INFO, 32'h1f, 32'h0e, "dn info");
        rd(12'h0f0, 32'hffff_ffff, 32'h0, "unmapped");
        $display("test reset done");
        wb_acc(1'b1, OFF_LINK_CS, 32'h0000_ffff);
        rd(OFF_LINK_CS, 32'hffff, 32'h0ed3, "dn ctl");
        chk("link ctl", {4'hf, 2'h3, EXT_FTS_COUNT, EXT_TS1_COUNT},
            {link.aspm_l0s_en, link.aspm_l1_en, link.link_dis, link.ext_sync, link.common_clk, link.hw_width_dis,
            link.fts_count, link.ts1_count});
        for (int k = 0; k < 4; k++)
        begin
            wb_acc(1'b1, OFF_LINK_CS, 32'(k));
            repeat (2) @(posedge clk_i);
            chk("aspm", {30'h0, k[0], k[1]}, {30'h0, link.aspm_l0s_en, link.aspm_l1_en});
        end
        chk("norm fts", 32'(NORM_FTS_COUNT), 32'(link.fts_count));
        $display("test control done");
        rd(OFF_LINK_CS, 32'h0800_0000, 32'h0800_0000, "in training");
        train(1'b1, 4'h1, 6'h01);
        rd(OFF_LINK_CS, 32'h0400_0000, 32'h0400_0000, "train err");
        train(1'b0, 4'h1, 6'h01);
        rd(OFF_LINK_CS, 32'hffff_0000, 32'h3011_0000, "trained");
        rd(OFF_IRQ_STS, 32'h7, 32'h7, "irq events");
        dly <= 8'h14;
        wb_acc(1'b1, OFF_LINK_CS, 32'h20);
        rd(OFF_LINK_CS, 32'h0800_0020, 32'h0800_0000, "retraining");
        repeat (30) @(posedge clk_i);
        rd(OFF_LINK_CS, 32'h0800_0000, 32'h0, "retrained");
        $display("test training done");
        @(posedge clk_i);
        bw <= 2'h3;
        @(posedge clk_i);
        bw <= 2'h0;
        repeat (3) @(posedge clk_i);
        chk("irq masked", 32'h0, {30'h0, lbw, irq});
        wb_acc(1'b1, OFF_LINK_CS, 32'h0c00);
        wb_acc(1'b1, OFF_IRQ_MASK, 32'h18);
        repeat (2) @(posedge clk_i);
        chk("irq raised", 32'h3, {30'h0, lbw, irq});
        rd(OFF_IRQ_MASK, 32'h1f, 32'h18, "mask");
        wb_acc(1'b1, OFF_LINK_CS, 32'h4000_0c00);
        rd(OFF_LINK_CS, 32'hc000_0000, 32'h8000_0000, "w1c bw");
        wb_acc(1'b1, OFF_LINK_CS, 32'h8000_0c00);
        repeat (2) @(posedge clk_i);
        chk("lbw clear", 32'h1, {30'h0, lbw, irq});
        wb_acc(1'b1, OFF_IRQ_STS, 32'h1f);
        repeat (2) @(posedge clk_i);
        chk("irq clear", 32'h0, {30'h0, lbw, irq});
        $display("test interrupt done");
        rst_i <= 1'b1;
        up <= 1'b1;
        slot_dflt <= 1'b0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFF_LINK_CS, 32'hffff_ffff, 32'h0842_0000, "up reset");
        wb_acc(1'b1, OFF_LINK_CS, 32'h0000_ffff);
        rd(OFF_LINK_CS, 32'hffff, 32'h03c3, "up ctl");
        rel <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("pin float", 32'h0, {31'h0, clkreq_n_oe_o});
        rd(OFF_PORT_INFO, 32'h1f, 32'h17, "up info");
        wb_acc(1'b1, OFF_LINK_CS, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("pin held", 32'h1, {31'h0, clkreq_n_oe_o});
        $display("test upstream done");
        end_of_test();
    end
endmodule
